// file: design/rst_ctl_defs.svh
// constants for the reset and force-off control block
`ifndef RST_CTL_DEFS_SVH
`define RST_CTL_DEFS_SVH
// =====================================================================
// widths and reset values
`define CUR_W         10
`define CFG_W         8
`define FLT_W         4
`define CUR_ZERO      10'h000
`define CFG_DEFAULT   8'h00
`define FLT_CLEAR     4'h0
`define SYNC_RESET    1'b1
// =====================================================================
// pull levels of the pins, reset values of the other synchronisers and the serial output park level
`define UV_SYNC_RESET   1'b0
`define TEST_SYNC_RESET 1'b0
`define PULL_UP         1'b1
`define PULL_DOWN       1'b0
`define SO_PARK         1'b0
`endif

// file: design/rst_ctl_pkg.sv
// types for the reset and force-off control block
`include "rst_ctl_defs.svh"
package rst_ctl_pkg;
    // command word for both channels from the serial decoder
    typedef struct packed {
        logic [`CUR_W-1:0] cur_a;
        logic [`CUR_W-1:0] cur_b;
        logic [`CFG_W-1:0] cfg;
    } cmd_s;
    // operating modes
    typedef enum logic [2:0] {
        MODE_RESET  = 3'b001,
        MODE_FORCED = 3'b010,
        MODE_RUN    = 3'b100
    } mode_e;
endpackage

// file: design/rst_force_ctl.sv
// reset and force-off control for a dual-channel current driver
// Summary of operation
// - power-on reset zeroes both channel currents
// - power-on reset restores configuration defaults
// - power-on reset clears all fault flags
// - channels stay off until valid command
// - logic undervoltage acts as full reset
// - force-off active high, open reads high
// - force-off holds currents zero, defaults
// - force-off drops commands, floats serial output
// - force-off keeps fault flags
// - after force-off, stays zero until commanded
// - faults during undervoltage are unreliable
// - test input active high, open reads low
`timescale 1ns/100ps
`include "rst_ctl_defs.svh"
module rst_force_ctl (
    input  wire logic                 clk,
    input  wire logic                 rst_n,       // power-on reset
    input  wire logic                 uv_n,        // logic supply good, low = undervoltage
    input  wire logic                 force_pin,   // force-off pin, pulled up
    input  wire logic                 force_pin_oe,// high when something drives the pin
    input  wire logic                 test_pin,    // production test pin, pulled down
    input  wire logic                 test_pin_oe, // high when something drives the pin
    input  wire logic                 cmd_valid,   // one-cycle command strobe
    input  rst_ctl_pkg::cmd_s         cmd,         // command payload
    input  wire logic [`FLT_W-1:0]    flt_set,     // fault events from diagnostics
    input  wire logic                 so_data,     // serial output data
    output logic [`CUR_W-1:0]         cur_a,       // commanded current channel a
    output logic [`CUR_W-1:0]         cur_b,       // commanded current channel b
    output logic [`CFG_W-1:0]         cfg,         // programmable settings
    output logic [`FLT_W-1:0]         flt,         // sticky fault flags
    output logic                      flt_valid,   // diagnostics trustworthy
    output logic                      so_out,      // serial output level
    output logic                      so_oe,       // serial output enable
    output logic                      cmd_taken,   // command accepted pulse
    output logic                      test_mode    // test mode level
);
    // =================================================================
    // pin resolution: undriven pins take their pull level
    // the pin model carries a driven value and a driver enable, so the
    // weak pull is modelled here instead of with a resolved net
    logic force_lvl;   // resolved force-off level
    logic test_lvl;    // resolved test level
    // open force pin reads as asserted: a broken wire fails safe
    assign force_lvl = force_pin_oe ? force_pin : `PULL_UP;
    // open test pin reads low so the part never drifts into test
    assign test_lvl  = test_pin_oe  ? test_pin  : `PULL_DOWN;

    // =================================================================
    // synchronisers
    logic force_s;     // synchronised force-off
    logic test_s;      // synchronised test level
    logic uv_s;        // synchronised supply good
    // force-off, reset to asserted: outputs stay off until the pin has
    // been seen low for two edges after reset
    sync2 #(.RST_VAL(`SYNC_RESET)) u_force (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (force_lvl),
        .q     (force_s)
    );
    // test level, reset to the inactive level of the pin
    sync2 #(.RST_VAL(`TEST_SYNC_RESET)) u_test (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (test_lvl),
        .q     (test_s)
    );
    // supply good, reset to bad so reset stretches two edges past rst_n
    sync2 #(.RST_VAL(`UV_SYNC_RESET)) u_uv (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (uv_n),
        .q     (uv_s)
    );

    // full reset: power-on or undervoltage
    logic full_rst;
    assign full_rst = !rst_n || !uv_s;
    // forced state, also async from the raw pin so outputs drop at once
    // limitation: a force-off pulse should last one full cycle; a shorter
    // glitch drops the outputs only while it lasts and may not reach the
    // synchroniser, so the registers would keep their contents
    logic forced;   // raw or synchronised force-off
    assign forced = force_s || force_lvl;

    // =================================================================
    // command acceptance
    // refused in reset and while the raw or synchronised pin is high,
    // so a command racing the pin edge is dropped rather than applied
    logic accept;   // command taken this cycle
    assign accept = cmd_valid && !forced && !full_rst;

    // =================================================================
    // mode tracking
    // only an accepted command leaves the idle modes; a refused strobe
    // must not make the block look commanded
    rst_ctl_pkg::mode_e mode_r;   // current operating mode
    always_ff @(posedge clk) begin
        if (full_rst) begin
            // power-on or supply reset
            mode_r <= rst_ctl_pkg::MODE_RESET;
        end else if (force_s) begin
            // pin held, stays here after release
            mode_r <= rst_ctl_pkg::MODE_FORCED;
        end else if (accept) begin
            // first valid command after reset or release
            mode_r <= rst_ctl_pkg::MODE_RUN;
        end
    end

    // =================================================================
    // command registers
    logic [`CUR_W-1:0] cur_a_r;
    logic [`CUR_W-1:0] cur_b_r;
    logic [`CFG_W-1:0] cfg_r;     // settings register
    // clear has priority over load: a command in the same cycle as a
    // reset or a held pin is lost, never half applied
    always_ff @(posedge clk) begin
        if (full_rst) begin
            cur_a_r <= `CUR_ZERO;
            cur_b_r <= `CUR_ZERO;
            cfg_r   <= `CFG_DEFAULT;
        end else if (force_s) begin
            cur_a_r <= `CUR_ZERO;
            cur_b_r <= `CUR_ZERO;
            cfg_r   <= `CFG_DEFAULT;
        end else if (accept) begin
            cur_a_r <= cmd.cur_a;
            cur_b_r <= cmd.cur_b;
            cfg_r   <= cmd.cfg;
        end
    end
    // async gating: raw pin zeroes outputs before the clock sees it
    assign cur_a = forced ? `CUR_ZERO    : cur_a_r;
    assign cur_b = forced ? `CUR_ZERO    : cur_b_r;
    assign cfg   = forced ? `CFG_DEFAULT : cfg_r;
    assign cmd_taken = accept;

    // =================================================================
    // fault flags: cleared only by full reset, sets are sticky
    logic [`FLT_W-1:0] flt_r;
    always_ff @(posedge clk) begin
        if (full_rst) begin
            flt_r <= `FLT_CLEAR;
        end else begin
            flt_r <= flt_r | flt_set;
        end
    end
    assign flt = flt_r;
    // diagnostics only trusted with good supply
    assign flt_valid = uv_s && rst_n;

    // =================================================================
    // serial output: floats while forced
    assign so_oe  = !forced && !full_rst;
    // parked low while disabled; the pad sees only so_oe, so the pin
    // floats whatever this level is
    assign so_out = so_oe ? so_data : `SO_PARK;
    assign test_mode = test_s;

    // =================================================================
    // checks
    // currents zero one cycle after any power-on reset edge
    AST_POR_ZERO: assert property (@(posedge clk)
        !rst_n |=> (cur_a == `CUR_ZERO && cur_b == `CUR_ZERO))
        else $error("currents not zero after reset");
    // settings back to default after reset
    AST_POR_CFG: assert property (@(posedge clk)
        !rst_n |=> cfg == `CFG_DEFAULT)
        else $error("config not default after reset");
    // fault flags cleared after reset
    AST_POR_FLT: assert property (@(posedge clk)
        !rst_n |=> flt == `FLT_CLEAR)
        else $error("faults not cleared after reset");
    // an idle output stays idle without a strobe
    AST_STAY_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        (cur_a == `CUR_ZERO && !cmd_valid) |=> cur_a == `CUR_ZERO)
        else $error("current rose without command");
    // an accepted command lands in the registers at its own edge
    AST_CMD_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_taken |=> (cur_a_r == $past(cmd.cur_a) && cur_b_r == $past(cmd.cur_b)
            && cfg_r == $past(cmd.cfg)))
        else $error("accepted command not loaded");
    // supply loss acts like power-on reset
    AST_UV_RESET: assert property (@(posedge clk) disable iff (!rst_n)
        !uv_s |=> (flt == `FLT_CLEAR && cur_b == `CUR_ZERO))
        else $error("undervoltage did not reset");
    // held pin zeroes outputs in the same cycle
    AST_FORCE_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        force_lvl |-> (cur_a == `CUR_ZERO && cfg == `CFG_DEFAULT))
        else $error("forced state not applied");
    // held pin floats the serial output and refuses commands
    AST_FORCE_SO: assert property (@(posedge clk) disable iff (!rst_n)
        force_lvl |-> (!so_oe && !cmd_taken))
        else $error("serial active while forced");
    // no flag may drop while forced with a good supply
    AST_FORCE_FLT: assert property (@(posedge clk) disable iff (!rst_n)
        (force_s && uv_s) |=> (flt & $past(flt)) == $past(flt))
        else $error("faults lost while forced");
    // registers already cleared when the pin is released
    AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(force_s) && !cmd_valid) |-> cur_a_r == `CUR_ZERO)
        else $error("current not zero on release");
    // until a command is accepted both currents and the settings stay at default
    AST_MODE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_r != rst_ctl_pkg::MODE_RUN) |->
            (cur_a_r == `CUR_ZERO && cur_b_r == `CUR_ZERO && cfg_r == `CFG_DEFAULT))
        else $error("settings not default while uncommanded");
    // open force pin reaches the synchronised level in two edges
    AST_OPEN_PIN: assert property (@(posedge clk) disable iff (!rst_n)
        !force_pin_oe |-> ##2 force_s)
        else $error("open force pin not asserted");
    // open test pin never reaches test mode
    AST_TEST_OPEN: assert property (@(posedge clk) disable iff (!rst_n)
        !test_pin_oe |-> ##2 !test_mode)
        else $error("open test pin reached test mode");
    // fault flags marked untrusted once the supply dip is seen
    AST_FLT_VALID: assert property (@(posedge clk) disable iff (!rst_n)
        !uv_n |-> ##2 !flt_valid)
        else $error("faults trusted during undervoltage");
    // main scenarios
    COV_CMD: cover property (@(posedge clk) disable iff (!rst_n) cmd_taken);
    COV_FORCE: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(force_s));
    COV_RELEASE: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(force_s));
    COV_OPEN: cover property (@(posedge clk) disable iff (!rst_n) !force_pin_oe);
    COV_UV: cover property (@(posedge clk) disable iff (!rst_n) $fell(uv_s));
endmodule // rst_force_ctl

// file: design/sync2.sv
// two-flop synchroniser for a pin level
`timescale 1ns/100ps
module sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic meta_r;   // first stage, read only by q
    // =================================================================
    // two stages
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // sync2

// file: dv/host_model.sv
// host model: force-off pin, supply monitor and command strobe
`timescale 1ns/100ps
module host_model (
    input  wire logic         clk,          // block clock
    input  wire logic         cmd_taken,    // acceptance from the block
    output logic              force_pin,    // pin level, pull-up when open
    output logic              force_pin_oe, // high while host drives pin
    output logic              uv_n,         // supply good
    output logic              cmd_valid,    // one-cycle command strobe
    output rst_ctl_pkg::cmd_s cmd           // command payload
);
    // idle: pin driven low, supply good, no command
    initial begin
        force_pin = 1'b0;
        force_pin_oe = 1'b1;
        uv_n = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // drive or open the pin; an open pin reads high through the pull-up
    task automatic force_off(input logic on, input logic drive);
        @(negedge clk);
        force_pin_oe = drive;
        force_pin = on | ~drive;
    endtask
    // supply dip: force is raised first, so the block never runs on a sagging supply
    task automatic dip(input logic low);
        if (low) force_off(1'b1, 1'b1);
        @(negedge clk);
        uv_n = ~low;
    endtask
    // one-cycle pulse; payload scrambled once the strobe drops
    task automatic send(input rst_ctl_pkg::cmd_s c, output logic taken);
        @(negedge clk);
        cmd = c;
        cmd_valid = 1'b1;
        #1 taken = cmd_taken;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd = ~c;
    endtask
endmodule // host_model

// file: dv/test_rst_force_ctl.sv
// self-checking bench for the reset and force-off control block
`timescale 1ns/100ps
`include "rst_ctl_defs.svh"
module test_rst_force_ctl;
    // ==============================================
    // signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic force_pin, force_pin_oe, uv_n, cmd_valid, cmd_taken, tk;
    logic test_pin = 1'b0;
    logic test_pin_oe = 1'b1;
    logic so_data = 1'b1;
    logic [`FLT_W-1:0] flt_set = '0;
    rst_ctl_pkg::cmd_s cmd;
    logic [`CUR_W-1:0] cur_a, cur_b;
    logic [`CFG_W-1:0] cfg;
    logic [`FLT_W-1:0] flt;
    logic flt_valid, so_out, so_oe, test_mode;
    int n_fail = 0;
    int n_checks = 0;
    // ==============================================
    // instances
    host_model i_host_model (.clk(clk), .cmd_taken(cmd_taken), .force_pin(force_pin),
        .force_pin_oe(force_pin_oe), .uv_n(uv_n), .cmd_valid(cmd_valid), .cmd(cmd));
    rst_force_ctl i_rst_force_ctl (.clk(clk), .rst_n(rst_n), .uv_n(uv_n),
        .force_pin(force_pin), .force_pin_oe(force_pin_oe), .test_pin(test_pin),
        .test_pin_oe(test_pin_oe), .cmd_valid(cmd_valid), .cmd(cmd), .flt_set(flt_set),
        .so_data(so_data), .cur_a(cur_a), .cur_b(cur_b), .cfg(cfg), .flt(flt),
        .flt_valid(flt_valid), .so_out(so_out), .so_oe(so_oe), .cmd_taken(cmd_taken),
        .test_mode(test_mode));
    // 40 MHz clock
    always #12.5 clk = ~clk;
    // compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // everything cleared and stays off without a command
    task automatic t_reset();
        repeat (8) @(negedge clk);
        chk("cur_a", 16'h0, cur_a);
        chk("cfg", 16'h0, cfg);
        chk("flt", 16'h0, flt);
        chk("cur_b", 16'h0, cur_b);
        $display("t_reset done");
    endtask
    // two commands one idle cycle apart and a sticky fault
    task automatic t_cmd();
        i_host_model.send('{10'h3ff, 10'h001, 8'ha5}, tk);
        chk("taken", 16'h1, tk);
        i_host_model.send('{10'h200, 10'h155, 8'h3c}, tk);
        chk("cur_a", 16'h200, cur_a);
        chk("cfg", 16'h3c, cfg);
        chk("cur_b", 16'h155, cur_b);
        chk("so_oe", 16'h1, so_oe);
        chk("so_out", 16'h1, so_out);
        chk("flt_valid", 16'h1, flt_valid);
        flt_set = 4'h9;
        @(negedge clk);
        flt_set = 4'h0;
        @(negedge clk);
        chk("flt", 16'h9, flt);
        $display("t_cmd done");
    endtask
    // forced state, refused command, release, open pin
    task automatic t_force();
        i_host_model.force_off(1'b1, 1'b1);
        #1 chk("cur_b", 16'h0, cur_b);
        chk("so_oe", 16'h0, so_oe);
        repeat (3) @(negedge clk);
        chk("cfg", 16'h0, cfg);
        chk("flt", 16'h9, flt);
        i_host_model.send('{10'h0aa, 10'h0bb, 8'h11}, tk);
        chk("taken", 16'h0, tk);
        i_host_model.force_off(1'b0, 1'b1);
        repeat (5) @(negedge clk);
        chk("cur_a", 16'h0, cur_a);
        chk("cfg", 16'h0, cfg);
        i_host_model.send('{10'h0aa, 10'h0bb, 8'h11}, tk);
        chk("taken", 16'h1, tk);
        chk("cur_a", 16'h0aa, cur_a);
        // open pin held long enough for the synchroniser to see it
        i_host_model.force_off(1'b0, 1'b0);
        #1 chk("cur_a", 16'h0, cur_a);
        repeat (3) @(negedge clk);
        chk("cur_b", 16'h0, cur_b);
        i_host_model.force_off(1'b0, 1'b1);
        repeat (3) @(negedge clk);
        chk("cur_a", 16'h0, cur_a);
        $display("t_force done");
    endtask
    // undervoltage clears the faults that force-off keeps
    task automatic t_uv();
        i_host_model.dip(1'b1);
        repeat (4) @(negedge clk);
        chk("flt", 16'h0, flt);
        chk("flt_valid", 16'h0, flt_valid);
        i_host_model.dip(1'b0);
        i_host_model.force_off(1'b0, 1'b1);
        repeat (3) @(negedge clk);
        chk("flt_valid", 16'h1, flt_valid);
        $display("t_uv done");
    endtask
    // a driven high reaches test mode, a released pin reads low again
    task automatic t_test();
        test_pin = 1'b1;
        repeat (4) @(negedge clk);
        chk("test_mode", 16'h1, test_mode);
        test_pin_oe = 1'b0;
        repeat (4) @(negedge clk);
        chk("test_mode", 16'h0, test_mode);
        test_pin_oe = 1'b1;
        test_pin = 1'b0;
        $display("t_test done");
    endtask
    // main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_cmd();
        t_force();
        t_uv();
        t_test();
        conclude();
    end
    // hang guard, about thirty times the expected run
    initial begin
        #(25 * 2000);
        n_fail++;
        conclude();
    end
endmodule // test_rst_force_ctl
